// ---- hw/lmm_top.sv ----
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "lmm_defs.svh"
// Contract
// - mute rising edge holds releases already high
// - releases set during muting are not held
// - mute falling edge ends muting
// - mute input used without debounce
// - mute time limit ends muting, max 7200 s
// - mute high at start does not mute
// - bypass rising edge forces all enabled releases high
// - bypass falling edge ends bypass
// - bypass input used without debounce
// - bypass time limit ends bypass, max 600 min
// - bypass high at start does not bypass
// - fault or chosen warning forces releases low
// - error clears automatically or on reset pulse
// - consolidate input1, input2, higher, lower, average
// - excess deviation sets error, drops release
// - tolerance time delays deviation error
// - STOP to START grants release for tolerance time
// - relative tolerance is value times percent over 100
// - OR combination uses the smaller tolerance
// - AND combination uses the larger tolerance
// - up to four limits, undershoot only
// - separate switch-on and switch-off thresholds
module lmm_top #(
    parameter int NLIM = 4,
    parameter int TICK_CYC = (`LMM_CLK_HZ / 1000) * `LMM_TICK_MS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensors
    input wire lmm_pkg::lmm_val_t val_1,
    input wire lmm_pkg::lmm_val_t val_2,
    input wire logic sensor_fault,
    input wire logic range_warn,
    // Control inputs
    input wire logic mute_in,
    input wire logic bypass_in,
    input wire logic err_reset_in,
    input wire logic run_in,
    // Outputs
    output logic [NLIM-1:0] rel_out,
    output logic rel_cond,
    output logic mute_active,
    output logic bypass_active,
    output logic error_out,
    output logic warn_out,
    output logic reset_req
);
    import lmm_pkg::*;

    // ==========================================
    // Parameter checks
    if (NLIM < 1 || NLIM > 4) begin : g_bad_nlim
        $error("NLIM must be 1 to 4");
    end
    if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_bad_tick
        $error("TICK_CYC must be 1 to 65535");
    end

    // ==========================================
    // Register file
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] mute_t_q, mute_t_d, byp_t_q, byp_t_d, tol_t_q, tol_t_d;
    logic [31:0] tol_abs_q, tol_abs_d;
    logic [7:0] tol_rel_q, tol_rel_d;
    lmm_val_t lim_on_q [NLIM], lim_on_d [NLIM];
    lmm_val_t lim_off_q [NLIM], lim_off_d [NLIM];
    logic [31:0] prdata_d, stat;
    logic hit, setup, wr;
    logic [1:0] idx;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & ~pslverr;
    assign idx = paddr[3:2];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        prdata_d = prdata;
        case (paddr)
            `LMM_OFS_CTRL: prdata_d = ctrl_q;
            `LMM_OFS_MUTE_T: prdata_d = {16'h0000, mute_t_q};
            `LMM_OFS_BYP_T: prdata_d = {16'h0000, byp_t_q};
            `LMM_OFS_TOL_ABS: prdata_d = tol_abs_q;
            `LMM_OFS_TOL_REL: prdata_d = {24'h00_0000, tol_rel_q};
            `LMM_OFS_TOL_T: prdata_d = {16'h0000, tol_t_q};
            `LMM_OFS_STAT: prdata_d = stat;
            default: begin
                hit = 1'b0;
                prdata_d = 32'h0000_0000;
                if (32'(idx) < NLIM && paddr[11:4] == `LMM_OFS_LIM_ON >> 4) begin
                    hit = 1'b1;
                    prdata_d = lim_on_q[idx];
                end
                if (32'(idx) < NLIM && paddr[11:4] == `LMM_OFS_LIM_OFF >> 4) begin
                    hit = 1'b1;
                    prdata_d = lim_off_q[idx];
                end
            end
        endcase
        if (!setup) begin
            prdata_d = prdata;
        end
    end

    // Register writes, times clamped to their maxima
    always_comb begin
        ctrl_d = ctrl_q;
        mute_t_d = mute_t_q;
        byp_t_d = byp_t_q;
        tol_abs_d = tol_abs_q;
        tol_rel_d = tol_rel_q;
        tol_t_d = tol_t_q;
        lim_on_d = lim_on_q;
        lim_off_d = lim_off_q;
        if (wr) begin
            case (paddr)
                `LMM_OFS_CTRL: ctrl_d = {18'h0_0000, pwdata[13:0]};
                `LMM_OFS_MUTE_T: mute_t_d = (pwdata[15:0] > `LMM_MUTE_MAX_S) ?
                    `LMM_MUTE_MAX_S : pwdata[15:0];
                `LMM_OFS_BYP_T: byp_t_d = (pwdata[15:0] > `LMM_BYP_MAX_MIN) ?
                    `LMM_BYP_MAX_MIN : pwdata[15:0];
                `LMM_OFS_TOL_ABS: tol_abs_d = pwdata;
                `LMM_OFS_TOL_REL: tol_rel_d = pwdata[7:0];
                `LMM_OFS_TOL_T: tol_t_d = (pwdata[15:0] > `LMM_TOL_MAX_MS) ?
                    `LMM_TOL_MAX_MS : pwdata[15:0];
                default: begin
                    if (paddr[11:4] == `LMM_OFS_LIM_ON >> 4) begin
                        lim_on_d[idx] = pwdata;
                    end
                    if (paddr[11:4] == `LMM_OFS_LIM_OFF >> 4) begin
                        lim_off_d[idx] = pwdata;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `LMM_CTRL_RST;
            mute_t_q <= 16'h0000;
            byp_t_q <= 16'h0000;
            tol_abs_q <= 32'h0000_0000;
            tol_rel_q <= 8'h00;
            tol_t_q <= 16'h0000;
            prdata <= 32'h0000_0000;
            for (int i = 0; i < NLIM; i++) begin
                lim_on_q[i] <= 32'h0000_0000;
                lim_off_q[i] <= 32'h0000_0000;
            end
        end else begin
            ctrl_q <= ctrl_d;
            mute_t_q <= mute_t_d;
            byp_t_q <= byp_t_d;
            tol_abs_q <= tol_abs_d;
            tol_rel_q <= tol_rel_d;
            tol_t_q <= tol_t_d;
            prdata <= prdata_d;
            lim_on_q <= lim_on_d;
            lim_off_q <= lim_off_d;
        end
    end

    // ==========================================
    // Configuration fields
    logic mute_en, byp_en, tlim_en, man_rst, warn_off, dual;
    lmm_tol_t tol_type;
    lmm_cons_t cons_type;
    logic [NLIM-1:0] mask;
    assign mute_en = ctrl_q[`LMM_F_MUTE_EN];
    assign byp_en = ctrl_q[`LMM_F_BYP_EN];
    assign tlim_en = ctrl_q[`LMM_F_TLIM_EN];
    assign man_rst = ctrl_q[`LMM_F_MAN_RST];
    assign warn_off = ctrl_q[`LMM_F_WARN_OFF];
    assign dual = ctrl_q[`LMM_F_DUAL];
    assign tol_type = lmm_tol_t'(ctrl_q[`LMM_F_TOL_LSB +: 3]);
    assign cons_type = lmm_cons_t'(ctrl_q[`LMM_F_CONS_LSB +: 3]);

    // ==========================================
    // Consolidation and tolerance arithmetic
    lmm_val_t cons;
    logic [32:0] sum, diff, cons_mag;
    logic [39:0] rel_tol;
    logic exc_abs, exc_rel, tol_exc;
    logic [NLIM-1:0] cmp;

    always_comb begin
        sum = {val_1[31], val_1} + {val_2[31], val_2};
        diff = (val_1 >= val_2) ? {val_1[31], val_1} - {val_2[31], val_2}
                                : {val_2[31], val_2} - {val_1[31], val_1};
        case (cons_type)
            LMM_CONS_IN1: cons = val_1;
            LMM_CONS_IN2: cons = val_2;
            LMM_CONS_HI: cons = (val_1 >= val_2) ? val_1 : val_2;
            LMM_CONS_LO: cons = (val_1 >= val_2) ? val_2 : val_1;
            default: cons = lmm_val_t'(sum[32:1]);
        endcase
        if (!dual) begin
            cons = val_1;
        end
        cons_mag = cons[31] ? 33'(-{cons[31], cons}) : {1'b0, cons};
        rel_tol = ({7'h00, cons_mag} * {32'h0000_0000, tol_rel_q}) / `LMM_PCT_DIV;
        exc_abs = {7'h00, diff} > {8'h00, tol_abs_q};
        exc_rel = {7'h00, diff} > rel_tol;
        case (tol_type)
            LMM_TOL_ABS: tol_exc = exc_abs;
            LMM_TOL_REL: tol_exc = exc_rel;
            LMM_TOL_OR: tol_exc = exc_abs | exc_rel;
            LMM_TOL_AND: tol_exc = exc_abs & exc_rel;
            default: tol_exc = 1'b0;
        endcase
        tol_exc = tol_exc & dual;
    end

    // One hysteresis comparator per limit
    for (genvar g = 0; g < NLIM; g++) begin : g_lim
        assign mask[g] = (g <= int'(ctrl_q[`LMM_F_NLIM_LSB +: 2]));
        lmm_hyst u_hyst (
            .pclk(pclk),
            .presetn(presetn),
            .en(mask[g]),
            .value(cons),
            .on_thr(lim_on_q[g]),
            .off_thr(lim_off_q[g]),
            .pass_q(cmp[g])
        );
    end

    // ==========================================
    // Mute, bypass, error and release state
    logic [15:0] tick_q, tick_d, tol_cnt_q, tol_cnt_d, grace_cnt_q, grace_cnt_d;
    logic [25:0] mute_cnt_q, mute_cnt_d, byp_cnt_q, byp_cnt_d, mute_lim, byp_lim;
    logic tick_ms, mute_prev_q, byp_prev_q, rst_prev_q, run_prev_q;
    logic mute_act_q, mute_act_d, byp_act_q, byp_act_d, grace_q, grace_d;
    logic err_q, err_d, cause, tol_err, mute_to, byp_to, mute_rise, byp_rise;
    logic [NLIM-1:0] held_q, held_d, rel_d;

    // Edges taken straight from the inputs, no filtering
    assign mute_rise = mute_in & ~mute_prev_q;
    assign byp_rise = bypass_in & ~byp_prev_q;
    assign mute_lim = {10'h000, mute_t_q} * `LMM_MS_PER_S;
    assign byp_lim = {10'h000, byp_t_q} * `LMM_MS_PER_MIN;
    assign mute_to = tlim_en & (mute_t_q != 16'h0000) & (mute_cnt_q >= mute_lim);
    assign byp_to = tlim_en & (byp_t_q != 16'h0000) & (byp_cnt_q >= byp_lim);
    assign tol_err = tol_exc & ~grace_q & (tol_cnt_q >= tol_t_q);
    assign cause = sensor_fault | (range_warn & warn_off) | tol_err;

    always_comb begin
        tick_ms = (tick_q == 16'(TICK_CYC - 1));
        tick_d = tick_ms ? 16'h0000 : tick_q + 16'h0001;
        // Muting: hold only releases high at the edge
        mute_act_d = mute_act_q;
        held_d = held_q;
        if (!mute_en || (!mute_in && mute_prev_q) || mute_to) begin
            mute_act_d = 1'b0;
        end else if (mute_rise) begin
            mute_act_d = 1'b1;
            held_d = rel_out;
        end
        mute_cnt_d = (!mute_act_d || mute_rise) ? 26'h000_0000 :
            mute_cnt_q + {25'h000_0000, tick_ms};
        // Bypass
        byp_act_d = byp_act_q;
        if (!byp_en || (!bypass_in && byp_prev_q) || byp_to) begin
            byp_act_d = 1'b0;
        end else if (byp_rise) begin
            byp_act_d = 1'b1;
        end
        byp_cnt_d = (!byp_act_d || byp_rise) ? 26'h000_0000 :
            byp_cnt_q + {25'h000_0000, tick_ms};
        // Deviation timer
        tol_cnt_d = 16'h0000;
        if (tol_exc) begin
            tol_cnt_d = tol_cnt_q + {15'h0000, tick_ms & (tol_cnt_q != 16'hFFFF)};
        end
        // Start-up window after STOP to START
        grace_d = grace_q & run_in & (grace_cnt_q < tol_t_q);
        grace_cnt_d = grace_cnt_q + {15'h0000, tick_ms};
        if (run_in && !run_prev_q && dual && tol_t_q != 16'h0000) begin
            grace_d = 1'b1;
            grace_cnt_d = 16'h0000;
        end
        // Error: a new cause wins over a clear
        err_d = cause | (err_q & man_rst & ~(err_reset_in & ~rst_prev_q));
        // Release priority: bypass, error, start-up window, evaluation with muting
        if (byp_act_d) begin
            rel_d = mask;
        end else if (err_d) begin
            rel_d = '0;
        end else if (grace_d) begin
            rel_d = mask;
        end else begin
            rel_d = mask & (cmp | (mute_act_d ? held_d : '0));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 16'h0000;
            mute_prev_q <= 1'b1;
            byp_prev_q <= 1'b1;
            rst_prev_q <= 1'b1;
            run_prev_q <= 1'b0;
            mute_act_q <= 1'b0;
            byp_act_q <= 1'b0;
            mute_cnt_q <= 26'h000_0000;
            byp_cnt_q <= 26'h000_0000;
            held_q <= '0;
            tol_cnt_q <= 16'h0000;
            grace_q <= 1'b0;
            grace_cnt_q <= 16'h0000;
            err_q <= 1'b0;
            rel_out <= '0;
            rel_cond <= 1'b0;
            warn_out <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            tick_q <= tick_d;
            mute_prev_q <= mute_in;
            byp_prev_q <= bypass_in;
            rst_prev_q <= err_reset_in;
            run_prev_q <= run_in;
            mute_act_q <= mute_act_d;
            byp_act_q <= byp_act_d;
            mute_cnt_q <= mute_cnt_d;
            byp_cnt_q <= byp_cnt_d;
            held_q <= held_d;
            tol_cnt_q <= tol_cnt_d;
            grace_q <= grace_d;
            grace_cnt_q <= grace_cnt_d;
            err_q <= err_d;
            rel_out <= rel_d;
            rel_cond <= |(cmp & mask);
            warn_out <= range_warn;
            reset_req <= err_d & ~cause & man_rst;
        end
    end

    assign mute_active = mute_act_q;
    assign bypass_active = byp_act_q;
    assign error_out = err_q;
    assign stat = {22'h00_0000, grace_q, reset_req, err_q, byp_act_q, mute_act_q,
        1'b0, 4'(rel_out)};

    // ==========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_mute_rise;
        mute_en && mute_in && !mute_prev_q && !mute_to;
    endsequence
    sequence s_byp_fall;
        byp_act_q && !bypass_in;
    endsequence

    AST_MUTE_HOLD: assert property (s_mute_rise |=> mute_act_q && held_q == $past(rel_out))
        else $error("muting did not capture the releases");
    AST_MUTE_END: assert property (mute_act_q && !mute_in |=> !mute_act_q)
        else $error("muting survived a falling edge");
    AST_MUTE_TO: assert property (mute_act_q && mute_to && mute_in |=>
        !mute_act_q ##1 !mute_act_q)
        else $error("muting outlived its time limit");
    AST_MUTE_EDGE: assert property ($rose(mute_act_q) |-> $past(mute_in) && $past(mute_rise))
        else $error("muting started without a rising edge");
    AST_BYP_ALL: assert property (byp_act_q |-> rel_out == $past(mask))
        else $error("bypass did not force the releases");
    AST_BYP_END: assert property (s_byp_fall |=> !byp_act_q)
        else $error("bypass survived a falling edge");
    AST_FAULT: assert property (sensor_fault && !byp_act_d |=> err_q && rel_out == '0)
        else $error("fault did not drop the releases");
    AST_AUTO_CLR: assert property (err_q && !man_rst && !cause |=> !err_q)
        else $error("error did not clear automatically");
    AST_TOL: assert property (tol_exc && tol_t_q == 16'h0000 && !grace_q |=> err_q)
        else $error("deviation did not raise the error");
endmodule : lmm_top
`default_nettype wire

// ---- common/lmm_defs.svh ----
`ifndef LMM_DEFS_SVH
`define LMM_DEFS_SVH

// ==========================================
// Register byte offsets
`define LMM_OFS_CTRL 12'h000
`define LMM_OFS_MUTE_T 12'h004
`define LMM_OFS_BYP_T 12'h008
`define LMM_OFS_TOL_ABS 12'h00C
`define LMM_OFS_TOL_REL 12'h010
`define LMM_OFS_TOL_T 12'h014
`define LMM_OFS_STAT 12'h018
`define LMM_OFS_LIM_ON 12'h020
`define LMM_OFS_LIM_OFF 12'h030

// ==========================================
// Control register fields
`define LMM_F_MUTE_EN 0
`define LMM_F_BYP_EN 1
`define LMM_F_TLIM_EN 2
`define LMM_F_MAN_RST 3
`define LMM_F_WARN_OFF 4
`define LMM_F_DUAL 5
`define LMM_F_TOL_LSB 6
`define LMM_F_CONS_LSB 9
`define LMM_F_NLIM_LSB 12
`define LMM_CTRL_RST 32'h0000_0014

// ==========================================
// Limits and timing
`define LMM_MUTE_MAX_S 16'h1C20
`define LMM_BYP_MAX_MIN 16'h0258
`define LMM_TOL_MAX_MS 16'hEA60
`define LMM_MS_PER_S 26'h00003E8
`define LMM_MS_PER_MIN 26'h000EA60
`define LMM_PCT_DIV 40'h00_0000_0064
`define LMM_CLK_HZ 40000000
`define LMM_TICK_MS 1

`endif

// ---- common/lmm_pkg.sv ----
`default_nettype none
package lmm_pkg;
    // Analog value in thousandths
    typedef logic signed [31:0] lmm_val_t;
    // Tolerance combination
    typedef enum logic [2:0] {
        LMM_TOL_NONE = 3'h0,
        LMM_TOL_ABS = 3'h1,
        LMM_TOL_REL = 3'h2,
        LMM_TOL_OR = 3'h3,
        LMM_TOL_AND = 3'h4
    } lmm_tol_t;
    // Consolidation method
    typedef enum logic [2:0] {
        LMM_CONS_AVG = 3'h0,
        LMM_CONS_IN1 = 3'h1,
        LMM_CONS_IN2 = 3'h2,
        LMM_CONS_HI = 3'h3,
        LMM_CONS_LO = 3'h4
    } lmm_cons_t;
endpackage : lmm_pkg
`default_nettype wire

// ---- hw/lmm_hyst.sv ----
`timescale 1ns/10ps
`default_nettype none
module lmm_hyst (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Comparison
    input wire logic en,
    input wire lmm_pkg::lmm_val_t value,
    input wire lmm_pkg::lmm_val_t on_thr,
    input wire lmm_pkg::lmm_val_t off_thr,
    output logic pass_q
);
    import lmm_pkg::*;

    logic pass_d;

    // Undershoot monitor: on above switch-on, off below switch-off
    always_comb begin
        pass_d = pass_q;
        if (!en) begin
            pass_d = 1'b0;
        end else if (value >= on_thr) begin
            pass_d = 1'b1;
        end else if (value < off_thr) begin
            pass_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pass_q <= 1'b0;
        end else begin
            pass_q <= pass_d;
        end
    end

    AST_HYST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        en && value < off_thr && value < on_thr |=> !pass_q)
        else $error("limit output stayed on below switch-off threshold");
endmodule : lmm_hyst
`default_nettype wire

// ---- test/lmm_sens_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lmm_sens_model (
    // Clock
    input wire logic pclk,
    // Sensor side
    output var lmm_pkg::lmm_val_t val_1,
    output var lmm_pkg::lmm_val_t val_2,
    output logic sensor_fault,
    output logic range_warn,
    // Operator side
    output logic mute_in,
    output logic bypass_in,
    output logic err_reset_in,
    output logic run_in
);
    import lmm_pkg::*;
    // Power-up levels, set by the bench at time zero before reset ends
    task automatic power_up(input lmm_val_t v, input logic [5:0] lv);
        val_1 = v;
        val_2 = v;
        {sensor_fault, range_warn, err_reset_in, run_in, bypass_in, mute_in} = lv;
    endtask : power_up
    // New analog values just after a rising edge
    task automatic set_vals(input lmm_val_t a, input lmm_val_t b);
        @(posedge pclk);
        val_1 <= a;
        val_2 <= b;
    endtask : set_vals
    // Fault and warning levels
    task automatic set_flags(input logic f, input logic w);
        @(posedge pclk);
        sensor_fault <= f;
        range_warn <= w;
    endtask : set_flags
    // Run, bypass and mute levels, clean edges with no bounce
    task automatic set_ctl(input logic [2:0] c);
        @(posedge pclk);
        {run_in, bypass_in, mute_in} <= c;
    endtask : set_ctl
    // Operator error reset, low-high-low over two edges
    task automatic pulse();
        @(posedge pclk);
        err_reset_in <= 1'b1;
        @(posedge pclk);
        err_reset_in <= 1'b0;
    endtask : pulse
endmodule : lmm_sens_model
`default_nettype wire

// ---- test/lmm_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lmm_defs.svh"
module lmm_top_tb_top;
    import lmm_pkg::*;
    typedef struct {lmm_val_t v; logic [31:0] s;} lmm_row_t;
    // One clock per millisecond tick keeps the time limits short
    localparam int TICK = 1;
    localparam logic [31:0] CB = 32'h0000_3013;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rel_cond, mute_active, bypass_active, error_out, warn_out, reset_req;
    logic [3:0] rel_out;
    lmm_val_t val_1, val_2;
    logic sensor_fault, range_warn, mute_in, bypass_in, err_reset_in, run_in;
    int error_cnt, comparisons;
    lmm_row_t rows [6] = '{'{5000, 32'hF}, '{3100, 32'h7}, '{2500, 32'h3},
        '{3100, 32'h3}, '{3300, 32'h7}, '{900, 32'h0}};
    logic [3:0] cons_exp [5] = '{4'h3, 4'h1, 4'h7, 4'h7, 4'h1};
    logic tol_exp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    lmm_top #(.NLIM(4), .TICK_CYC(TICK)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .val_1(val_1), .val_2(val_2), .sensor_fault(sensor_fault),
        .range_warn(range_warn), .mute_in(mute_in), .bypass_in(bypass_in),
        .err_reset_in(err_reset_in), .run_in(run_in), .rel_out(rel_out),
        .rel_cond(rel_cond), .mute_active(mute_active),
        .bypass_active(bypass_active), .error_out(error_out),
        .warn_out(warn_out), .reset_req(reset_req));
    lmm_sens_model sens (.pclk(pclk), .val_1(val_1), .val_2(val_2),
        .sensor_fault(sensor_fault), .range_warn(range_warn), .mute_in(mute_in),
        .bypass_in(bypass_in), .err_reset_in(err_reset_in), .run_in(run_in));

    // ==========================================
    // Clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ==========================================
    // Checking and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    // Setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Let outputs settle, then sample between edges
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : wt
    // Status seen on the ports and through the status register
    task automatic st(input logic [31:0] e);
        check({23'h0, reset_req, error_out, bypass_active, mute_active, 1'b0, rel_out}, e);
        apb(1'b0, `LMM_OFS_STAT, 32'h0);
        check(rd & 32'h0000_01FF, e);
    endtask : st

    // ==========================================
    // Watchdog, longer than the whole sequence
    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        summarize();
    end

    // ==========================================
    // Main sequence
    initial begin
        error_cnt = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sens.power_up(32'sh0, 6'b000011);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `LMM_OFS_CTRL, 32'h0);
        check(rd, 32'h0000_0014);
        apb(1'b0, 12'h040, 32'h0);
        check({rd[30:0], perr}, 32'h1);
        apb(1'b1, `LMM_OFS_CTRL, CB);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `LMM_OFS_LIM_ON + 12'(4 * i), 32'(1200 + 1000 * i));
            apb(1'b1, `LMM_OFS_LIM_OFF + 12'(4 * i), 32'(1000 + 1000 * i));
        end
        apb(1'b0, `LMM_OFS_LIM_ON + 12'h008, 32'h0);
        check(rd, 32'd3200);
        wt(2);
        st(32'h0);
        sens.set_ctl(3'b000);
        // Threshold table with hysteresis
        foreach (rows[i]) begin
            sens.set_vals(rows[i].v, rows[i].v);
            wt(3);
            check(32'(rel_cond), 32'(rows[i].s != 0));
            st(rows[i].s);
        end
        // Muting holds only what was high at the edge
        sens.set_vals(2500, 2500);
        wt(3);
        sens.set_ctl(3'b001);
        wt(3);
        sens.set_vals(900, 900);
        wt(3);
        st(32'h23);
        sens.set_vals(5000, 5000);
        wt(3);
        st(32'h2F);
        sens.set_vals(900, 900);
        wt(3);
        st(32'h23);
        sens.set_ctl(3'b000);
        wt(3);
        st(32'h0);
        // Mute time limit of one second, restarted on each activation
        apb(1'b1, `LMM_OFS_MUTE_T, 32'h1);
        apb(1'b1, `LMM_OFS_CTRL, CB | 32'h4);
        sens.set_vals(2500, 2500);
        sens.set_ctl(3'b001);
        wt(990);
        st(32'h23);
        wt(20);
        st(32'h03);
        sens.set_ctl(3'b000);
        sens.set_ctl(3'b001);
        wt(990);
        check(32'(mute_active), 32'h1);
        sens.set_ctl(3'b000);
        // Bypass, open and with a one minute limit
        sens.set_vals(900, 900);
        apb(1'b1, `LMM_OFS_CTRL, CB);
        sens.set_ctl(3'b010);
        wt(3);
        st(32'h4F);
        sens.set_ctl(3'b000);
        wt(3);
        st(32'h0);
        apb(1'b1, `LMM_OFS_BYP_T, 32'h1);
        apb(1'b1, `LMM_OFS_CTRL, CB | 32'h4);
        sens.set_ctl(3'b010);
        wt(59980);
        st(32'h4F);
        wt(20);
        st(32'h0);
        sens.set_ctl(3'b000);
        // Faults and warnings, automatic then manual error reset
        apb(1'b1, `LMM_OFS_CTRL, CB);
        sens.set_vals(5000, 5000);
        sens.set_flags(1'b1, 1'b0);
        wt(3);
        st(32'h80);
        sens.set_flags(1'b0, 1'b0);
        wt(3);
        st(32'hF);
        sens.set_flags(1'b0, 1'b1);
        wt(3);
        check({warn_out, rel_out}, 32'h10);
        sens.set_flags(1'b0, 1'b0);
        apb(1'b1, `LMM_OFS_CTRL, CB | 32'h8);
        sens.set_flags(1'b1, 1'b0);
        sens.set_flags(1'b0, 1'b0);
        wt(3);
        st(32'h180);
        sens.pulse();
        wt(3);
        st(32'hF);
        // Two limits enabled: the upper lanes stay off
        apb(1'b1, `LMM_OFS_CTRL, 32'h0000_1013);
        wt(3);
        check(32'(rel_out), 32'h3);
        // Every consolidation method
        for (int c = 0; c < 5; c++) begin
            sens.set_vals(900, 900);
            apb(1'b1, `LMM_OFS_CTRL, CB | 32'h20 | (32'(c) << 9));
            sens.set_vals(2100, 3300);
            wt(3);
            check(32'(rel_out), 32'(cons_exp[c]));
        end
        // Every tolerance type, deviation 400 around 3200
        apb(1'b1, `LMM_OFS_TOL_ABS, 32'd500);
        apb(1'b1, `LMM_OFS_TOL_REL, 32'd10);
        for (int t = 0; t < 5; t++) begin
            sens.set_vals(3000, 3000);
            apb(1'b1, `LMM_OFS_CTRL, CB | 32'h20 | (32'(t) << 6));
            sens.set_vals(3000, 3400);
            wt(3);
            check({error_out, rel_out}, tol_exp[t] ? 32'h10 : 32'h7);
        end
        // Tolerance time of 50 ms, then start-up grace
        sens.set_vals(3000, 3000);
        apb(1'b1, `LMM_OFS_TOL_T, 32'd50);
        apb(1'b1, `LMM_OFS_CTRL, CB | 32'h60);
        sens.set_vals(3000, 3600);
        wt(20);
        check({error_out, rel_out}, 32'h7);
        wt(50);
        check({error_out, rel_out}, 32'h10);
        sens.set_vals(900, 900);
        wt(3);
        sens.set_ctl(3'b100);
        wt(3);
        check(32'(rel_out), 32'hF);
        wt(60);
        check(32'(rel_out), 32'h0);
        summarize();
    end
endmodule : lmm_top_tb_top
`default_nettype wire
